// ==== design/smbba_slave.sv ====
// Device end: two-wire slave decoding register and block transactions
module smbba_slave #(
    parameter logic [7:0] TOP = smbba_pkg::REG_TOP
) (
    input  wire logic       clk,         // System clock
    input  wire logic       rstn,        // Async reset, active low
    smbba_if.dev            bus,         // Two-wire link
    input  wire logic [6:0] slvAddr,     // Selected slave address
    output logic      [7:0] regAddr,     // Register whose data is wanted next
    input  wire logic [7:0] regRdData,   // Data of regAddr, same clock
    output logic            regWrEn,     // Write strobe, one cycle
    output logic            regRdDone,   // Byte fully read, one cycle
    output logic      [7:0] regStbAddr,  // Address for either strobe
    output logic      [7:0] regWrData    // Data for the write strobe
);
    import smbba_pkg::*;

    typedef struct packed {
        smbba_st_t  st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic       rw;
        logic       mAck;
        logic [2:0] idx;
        logic       blkCmd;
        logic       blkRd;
        logic       cntPend;
        logic [7:0] base;
        logic [7:0] ptr;
        logic [7:0] blkLen;
        logic       sclP;
        logic       sdaP;
        logic       pinLvl;
        logic       sdaOe;
        logic       wrEn;
        logic       rdDone;
        logic [7:0] stbAddr;
        logic [7:0] wrData;
    } smbba_slv_t;

    localparam smbba_slv_t SLV_RST = '{st: ST_IDLE, base: BASE_RST, blkLen: BLK_LEN_RST,
                                      sclP: 1'b1, sdaP: 1'b1, default: '0};

    smbba_slv_t r;
    smbba_slv_t n;
    logic       sclS;
    logic       sdaS;
    logic       rise;
    logic       fall;
    logic       startC;
    logic       stopC;
    logic       inSpace;
    logic [7:0] nxtPtr;
    logic [7:0] txByte;

    smbba_sync #(.W(2)) uSync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({bus.scl, bus.sda}),
        .q    ({sclS, sdaS})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus events are taken from the synchronised lines and their last values
    assign rise    = sclS & ~r.sclP;
    assign fall    = ~sclS & r.sclP;
    assign startC  = sclS & r.sclP & r.sdaP & ~sdaS;
    assign stopC   = sclS & r.sclP & ~r.sdaP & sdaS;
    assign inSpace = (r.ptr <= TOP);
    assign nxtPtr  = (r.ptr == ADDR_MAX) ? r.ptr : r.ptr + 8'h01;
    assign txByte  = r.cntPend ? r.blkLen
                   : (inSpace ? regRdData : BYTE_ZERO);

    ////////////////////////////////////////////////////////////////////////////
    // A START resets the bit counter and a STOP returns to idle, so a partial byte is dropped
    // before anything is committed; commits only happen once the byte's ack slot is reached.
    always_comb begin
        n = r;
        n.wrEn   = 1'b0;
        n.rdDone = 1'b0;
        n.sclP   = sclS;
        n.sdaP   = sdaS;
        if (startC) begin
            n.st    = ST_ADR;
            n.cnt   = 4'h0;
            n.sdaOe = 1'b0;
        end else if (stopC) begin
            n.st     = ST_IDLE;
            n.sdaOe  = 1'b0;
            n.blkCmd = 1'b0;
        end else begin
            unique case (r.st)
                ST_IDLE: begin
                end
                ST_ADR, ST_RX: begin
                    if (rise && r.cnt < BIT_ACK) begin
                        n.sh  = {r.sh[6:0], sdaS};
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall && r.cnt == BIT_ACK) begin
                        if (r.st == ST_RX) begin
                            n.sdaOe = 1'b1;
                            n.cnt   = BIT_ACKEND;
                        end else if (r.sh[7:1] == slvAddr) begin
                            n.sdaOe = 1'b1;
                            n.cnt   = BIT_ACKEND;
                            n.rw    = r.sh[0];
                            if (r.sh[0]) begin
                                n.ptr     = r.base;
                                n.blkRd   = r.blkCmd;
                                n.cntPend = r.blkCmd;
                            end
                        end else begin
                            n.st = ST_IDLE;
                        end
                    end else if (fall && r.cnt == BIT_ACKEND) begin
                        n.cnt   = 4'h0;
                        n.sdaOe = 1'b0;
                        if (r.st == ST_ADR) begin
                            if (r.rw) begin
                                n.st    = ST_TX;
                                n.sh    = txByte;
                                n.sdaOe = ~txByte[7];
                            end else begin
                                n.st     = ST_RX;
                                n.idx    = 3'h0;
                                n.blkCmd = 1'b0;
                            end
                        end else begin
                            n.idx = (r.idx == IDX_MAX) ? r.idx : r.idx + 3'h1;
                            if (r.idx == 3'h0) begin
                                if (r.sh == BLK_RD_CMD) begin
                                    n.blkCmd = 1'b1;
                                end else begin
                                    n.base = r.sh;
                                    n.ptr  = r.sh;
                                end
                            end else if (r.blkCmd) begin
                                // Count byte and anything past the length are ignored
                                if (r.idx == PC_IDX_ADR) begin
                                    n.base = r.sh;
                                end else if (r.idx == PC_IDX_LEN) begin
                                    n.blkLen = r.sh;
                                end
                            end else begin
                                if (inSpace) begin
                                    n.wrEn    = 1'b1;
                                    n.stbAddr = r.ptr;
                                    n.wrData  = r.sh;
                                end
                                n.ptr = nxtPtr;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (rise && r.cnt < BIT_ACK) begin
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall && r.cnt != 4'h0 && r.cnt < BIT_ACK) begin
                        n.sh    = {r.sh[6:0], 1'b0};
                        n.sdaOe = ~r.sh[6];
                    end else if (fall && r.cnt == BIT_ACK) begin
                        n.sdaOe = 1'b0;
                        n.cnt   = BIT_ACKEND;
                    end else if (rise && r.cnt == BIT_ACKEND) begin
                        // The byte counts as read only once its ack slot is reached
                        n.mAck = ~sdaS;
                        if (r.cntPend) begin
                            n.cntPend = 1'b0;
                        end else begin
                            n.rdDone  = 1'b1;
                            n.stbAddr = r.ptr;
                            n.ptr     = nxtPtr;
                            if (sdaS && r.blkRd) begin
                                n.base = nxtPtr;
                            end
                        end
                    end else if (fall && r.cnt == BIT_ACKEND) begin
                        n.cnt = 4'h0;
                        if (r.mAck) begin
                            n.sh    = txByte;
                            n.sdaOe = ~txByte[7];
                        end else begin
                            n.st    = ST_IDLE;
                            n.sdaOe = 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= SLV_RST;
        end else begin
            r <= n;
        end
    end

    assign bus.dSdaO  = r.pinLvl;
    assign bus.dSdaOe = r.sdaOe;
    assign regAddr    = r.ptr;
    assign regWrEn    = r.wrEn;
    assign regRdDone  = r.rdDone;
    assign regStbAddr = r.stbAddr;
    assign regWrData  = r.wrData;
endmodule

// ==== design/smbba_pkg.sv ====
// Shared constants and types for the two-wire block access engine
package smbba_pkg;
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          SCL_PERIOD_NS = 10000;
    localparam int          SCL_QTR_CYC   = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;
    localparam logic [7:0]  REG_TOP       = 8'hEF;
    localparam logic [7:0]  ADDR_MAX      = 8'hFF;
    localparam logic [7:0]  BLK_RD_CMD    = 8'hF1;
    localparam logic [7:0]  BASE_RST      = 8'h00;
    localparam logic [7:0]  BLK_LEN_RST   = 8'h01;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [3:0]  BIT_ACK       = 4'h8;
    localparam logic [3:0]  BIT_ACKEND    = 4'h9;
    localparam logic [2:0]  PC_IDX_ADR    = 3'h2;
    localparam logic [2:0]  PC_IDX_LEN    = 3'h3;
    localparam logic [2:0]  IDX_MAX       = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADR  = 2'b01,
        ST_RX   = 2'b11,
        ST_TX   = 2'b10
    } smbba_st_t;

    typedef enum logic [1:0] {
        OP_START = 2'b00,
        OP_WR    = 2'b01,
        OP_RD    = 2'b11,
        OP_STOP  = 2'b10
    } smbba_op_t;
endpackage

// ==== design/smbba_if.sv ====
// Open-drain two-wire link joining the host end and the device end
interface smbba_if;
    logic hSclO;
    logic hSclOe;
    logic hSdaO;
    logic hSdaOe;
    logic dSdaO;
    logic dSdaOe;
    wire  scl;
    wire  sda;

    // Pull-ups: a line is low only while some end enables a low drive
    assign scl = ~(hSclOe & ~hSclO);
    assign sda = ~((hSdaOe & ~hSdaO) | (dSdaOe & ~dSdaO));

    modport host (output hSclO, output hSclOe, output hSdaO, output hSdaOe,
                  input scl, input sda);
    modport dev  (output dSdaO, output dSdaOe, input scl, input sda);
endinterface

// ==== design/smbba_sync.sv ====
// Two-flop synchroniser for pin inputs, resetting to the idle-high level
module smbba_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,   // System clock
    input  wire logic         rstn,  // Async reset, active low
    input  wire logic [W-1:0] d,     // Asynchronous input
    output logic      [W-1:0] q      // Synchronised output
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '1;
            q    <= '1;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ==== design/smbba_host.sv ====
// Host end: makes the serial clock and runs one bus step per command
module smbba_host #(
    parameter int QTR = smbba_pkg::SCL_QTR_CYC
) (
    input  wire logic                 clk,       // System clock
    input  wire logic                 rstn,      // Async reset, active low
    smbba_if.host                     bus,       // Two-wire link
    input  wire logic                 cmdValid,  // Command request
    input  wire smbba_pkg::smbba_op_t cmdOp,     // START, write, read or STOP
    input  wire logic [7:0]           cmdData,   // Byte to send
    input  wire logic                 cmdAck,    // Read: 1 acknowledges the byte
    output logic                      cmdReady,  // Idle, command accepted
    output logic                      rspValid,  // Step finished, one cycle
    output logic      [7:0]           rspData,   // Byte received
    output logic                      rspAck     // Write: device acknowledged
);
    import smbba_pkg::*;

    localparam logic [15:0] QTR_M1 = 16'(QTR - 1);

    typedef struct packed {
        logic       ready;
        smbba_op_t  op;
        logic [1:0] q;
        logic [3:0] bitI;
        logic [15:0] tick;
        logic [7:0] sh;
        logic       ackBit;
        logic       pinLvl;
        logic       sclOe;
        logic       sdaOe;
        logic       rspValid;
        logic [7:0] rspData;
        logic       rspAck;
    } smbba_host_t;

    localparam smbba_host_t HOST_RST = '{ready: 1'b1, op: OP_START, default: '0};

    smbba_host_t r;
    smbba_host_t n;
    logic        sdaS;
    logic [3:0]  lastBit;

    smbba_sync #(.W(1)) uSync (
        .clk  (clk),
        .rstn (rstn),
        .d    (bus.sda),
        .q    (sdaS)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Each bit is four quarters: SCL low, data set, SCL high, sample.
    // Data only moves while SCL is low, except in START and STOP steps.
    always_comb begin
        n = r;
        n.rspValid = 1'b0;
        lastBit = (r.op == OP_START || r.op == OP_STOP) ? 4'h0 : BIT_ACK;
        if (r.ready) begin
            if (cmdValid) begin
                n.ready  = 1'b0;
                n.op     = cmdOp;
                n.sh     = cmdData;
                n.ackBit = cmdAck;
                n.q      = 2'h0;
                n.bitI   = 4'h0;
                n.tick   = 16'h0000;
                n.sclOe  = 1'b1;
            end
        end else if (r.tick != QTR_M1) begin
            n.tick = r.tick + 16'h0001;
        end else begin
            n.tick = 16'h0000;
            unique case (r.q)
                2'h0: begin
                    n.q = 2'h1;
                    unique case (r.op)
                        OP_START: n.sdaOe = 1'b0;
                        OP_STOP:  n.sdaOe = 1'b1;
                        OP_WR:    n.sdaOe = (r.bitI != BIT_ACK) & ~r.sh[7];
                        OP_RD:    n.sdaOe = (r.bitI == BIT_ACK) & r.ackBit;
                    endcase
                end
                2'h1: begin
                    n.q     = 2'h2;
                    n.sclOe = 1'b0;
                end
                2'h2: begin
                    n.q = 2'h3;
                    if (r.op == OP_START) begin
                        n.sdaOe = 1'b1;
                    end
                    if (r.op == OP_STOP) begin
                        n.sdaOe = 1'b0;
                    end
                end
                2'h3: begin
                    if (r.op == OP_WR) begin
                        if (r.bitI == BIT_ACK) begin
                            n.rspAck = ~sdaS;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                        end
                    end
                    if (r.op == OP_RD && r.bitI != BIT_ACK) begin
                        n.sh = {r.sh[6:0], sdaS};
                    end
                    if (r.bitI == lastBit) begin
                        n.ready    = 1'b1;
                        n.rspValid = 1'b1;
                        n.rspData  = r.sh;
                    end else begin
                        n.bitI  = r.bitI + 4'h1;
                        n.q     = 2'h0;
                        n.sclOe = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= HOST_RST;
        end else begin
            r <= n;
        end
    end

    assign bus.hSclO  = r.pinLvl;
    assign bus.hSclOe = r.sclOe;
    assign bus.hSdaO  = r.pinLvl;
    assign bus.hSdaOe = r.sdaOe;
    assign cmdReady   = r.ready;
    assign rspValid   = r.rspValid;
    assign rspData    = r.rspData;
    assign rspAck     = r.rspAck;
endmodule

// ==== verif/smbba_monitor.sv ====
// Wire-level checks on the two-wire link between the host end and the device end
module smbba_monitor (
    input wire logic clk,     // System clock
    input wire logic rstn,    // Async reset, active low
    input wire logic hSclO,   // Host clock drive level
    input wire logic hSclOe,  // Host pulls clock low
    input wire logic hSdaO,   // Host data drive level
    input wire logic hSdaOe,  // Host pulls data low
    input wire logic dSdaO,   // Device data drive level
    input wire logic dSdaOe,  // Device pulls data low
    input wire logic scl,     // Resolved clock line
    input wire logic sda      // Resolved data line
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    // Open-drain: an enabled drive is always a low drive
    a_dev_drive_low: assert property (dSdaOe |-> !dSdaO && !sda)
        else $error("device drives data high");
    a_host_drive_low: assert property ((hSclOe | hSdaOe) |-> !(hSclO | hSdaO) && (!hSclOe || !scl))
        else $error("host drives a line high");
    a_reset_lines_free: assert property ($rose(rstn) |-> !hSclOe && !hSdaOe && !dSdaOe)
        else $error("a line is held low right after reset");

    ////////////////////////////////////////////////////////////////////////////////
    // Device changes data only while the clock is low, so the device never sees a fake START/STOP
    a_ack_on_low: assert property ($rose(dSdaOe) |-> !scl)
        else $error("device starts driving while clock is high");
    a_rel_on_low: assert property ($fell(dSdaOe) |-> !scl)
        else $error("device releases data while clock is high");
    a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(dSdaOe))
        else $error("device data changes during clock high");
    // Longest legal low drive is an ack followed by an all-zero byte
    a_dev_drive_bound: assert property ($rose(dSdaOe) |-> ##[1:320] !dSdaOe)
        else $error("device holds data low too long");

    ////////////////////////////////////////////////////////////////////////////////
    // Clock phases long enough for the device's synchronisers
    a_scl_low_min: assert property ($fell(scl) |=> !scl [* 8])
        else $error("clock low phase too short");
    a_scl_high_min: assert property ($rose(scl) |=> scl [* 8])
        else $error("clock high phase too short");
endmodule

// ==== verif/tb.sv ====
// Self-checking bench: host end and device end joined on one link
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import smbba_pkg::*;

    localparam logic [6:0] SLV = 7'h2C;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       cmdValid = 1'b0;
    smbba_op_t  cmdOp = OP_START;
    logic [7:0] cmdData = 8'h00;
    logic       cmdAck = 1'b0;
    logic       cmdReady, rspValid, rspAck, regWrEn, regRdDone;
    logic [7:0] rspData, regAddr, regRdData, regStbAddr, regWrData;
    logic [7:0] mem [256];
    int         mismatches = 0;
    int         tests_run = 0;
    int         wrCnt = 0;
    int         rdCnt = 0;

    smbba_if bus ();
    always #5 clk = ~clk;

    smbba_host #(.QTR(8)) u_smbba_host (.clk(clk), .rstn(rstn), .bus(bus),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData), .cmdAck(cmdAck),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .rspAck(rspAck));
    smbba_slave u_smbba_slave (.clk(clk), .rstn(rstn), .bus(bus), .slvAddr(SLV),
        .regAddr(regAddr), .regRdData(regRdData), .regWrEn(regWrEn),
        .regRdDone(regRdDone), .regStbAddr(regStbAddr), .regWrData(regWrData));
    smbba_monitor u_smbba_monitor (.clk(clk), .rstn(rstn), .hSclO(bus.hSclO),
        .hSclOe(bus.hSclOe), .hSdaO(bus.hSdaO), .hSdaOe(bus.hSdaOe), .dSdaO(bus.dSdaO),
        .dSdaOe(bus.dSdaOe), .scl(bus.scl), .sda(bus.sda));

    ////////////////////////////////////////////////////////////////////////////////
    // Register file; out-of-space cells hold nonzero data so a zero-fill slip shows.
    // Strobes are looked at mid-cycle, away from the edge that launches them.
    assign regRdData = mem[regAddr];
    always @(negedge clk) begin
        if (regWrEn === 1'b1) begin
            chk("wr_in_space", {7'h00, regStbAddr > REG_TOP}, 8'h00);
            mem[regStbAddr] <= regWrData;
            wrCnt <= wrCnt + 1;
        end
        if (regRdDone === 1'b1) begin
            rdCnt <= rdCnt + 1;
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic tmo();
        mismatches++;
        $display("CHECK FAILED handshake expected response seen none");
        final_report();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // One host command: held until taken, then wait for its single-cycle response
    task automatic step(input smbba_op_t op, input logic [7:0] d, input logic a);
        int n;
        n = 0;
        @(negedge clk);
        cmdValid = 1'b1;
        cmdOp = op;
        cmdData = d;
        cmdAck = a;
        // Ready is seen mid-cycle, so the following rising edge takes the command
        while (cmdReady !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 400) tmo();
        end
        @(negedge clk);
        cmdValid = 1'b0;
        n = 0;
        while (rspValid !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 400) tmo();
        end
    endtask

    task automatic wr(input logic [7:0] d, input logic ea);
        step(OP_WR, d, 1'b0);
        chk("ack", {7'h00, rspAck}, {7'h00, ea});
    endtask

    task automatic rd(input logic a, input logic [7:0] exp, input string nm);
        step(OP_RD, 8'h00, a);
        chk(nm, rspData, exp);
        if (!a) chk("sda_free", {7'h00, bus.sda}, 8'h01);
    endtask

    task automatic hdr(input logic rw);
        step(OP_START, 8'h00, 1'b0);
        wr({SLV, rw}, 1'b1);
    endtask

    task automatic stop();
        step(OP_STOP, 8'h00, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Block write across the top of the space: last byte acked but dropped
    task automatic t_write();
        int w0;
        w0 = wrCnt;
        hdr(1'b0);
        wr(8'hEE, 1'b1);
        wr(8'h11, 1'b1);
        wr(8'h22, 1'b1);
        wr(8'h33, 1'b1);
        stop();
        chk("ee", mem[8'hEE], 8'h11);
        chk("ef", mem[8'hEF], 8'h22);
        chk("wr_count", 8'(wrCnt - w0), 8'h02);
    endtask

    task automatic t_read();
        hdr(1'b0);
        wr(8'h10, 1'b1);
        hdr(1'b1);
        rd(1'b0, mem[8'h10], "byte");
        stop();
        hdr(1'b0);
        wr(8'h20, 1'b1);
        hdr(1'b1);
        rd(1'b1, mem[8'h20], "lo");
        rd(1'b0, mem[8'h21], "hi");
        stop();
        hdr(1'b1);
        rd(1'b0, mem[8'h20], "base_kept");
        stop();
    endtask

    // Process call asking for the longest block, cut short after three data bytes
    task automatic t_pcall();
        int r0;
        r0 = rdCnt;
        hdr(1'b0);
        wr(BLK_RD_CMD, 1'b1);
        wr(8'h02, 1'b1);
        wr(8'h30, 1'b1);
        wr(8'h20, 1'b1);
        hdr(1'b1);
        rd(1'b1, 8'h20, "count");
        rd(1'b1, mem[8'h30], "d0");
        rd(1'b1, mem[8'h31], "d1");
        rd(1'b0, mem[8'h32], "d2");
        stop();
        chk("rd_done", 8'(rdCnt - r0), 8'h03);
        hdr(1'b1);
        rd(1'b0, mem[8'h33], "base_next");
        stop();
    endtask

    // Split process call; this bench has a single host on the link
    task automatic t_emul();
        hdr(1'b0);
        wr(BLK_RD_CMD, 1'b1);
        wr(8'h02, 1'b1);
        wr(8'h40, 1'b1);
        wr(8'h03, 1'b1);
        stop();
        for (int k = 0; k < 2; k++) begin
            hdr(1'b0);
            wr(BLK_RD_CMD, 1'b1);
            hdr(1'b1);
            rd(1'b1, 8'h03, "emul_count");
            for (int j = 0; j < 3; j++) rd(j < 2, mem[8'h40 + 3 * k + j], "emul_data");
            stop();
        end
    endtask

    // Block read at the very top: zero fill, and the base must not wrap to 00h
    task automatic t_edge();
        hdr(1'b0);
        wr(BLK_RD_CMD, 1'b1);
        wr(8'h02, 1'b1);
        wr(8'hFE, 1'b1);
        wr(8'h01, 1'b1);
        hdr(1'b1);
        rd(1'b1, 8'h01, "edge_count");
        rd(1'b1, 8'h00, "fe");
        rd(1'b0, 8'h00, "ff");
        stop();
        hdr(1'b1);
        rd(1'b0, 8'h00, "no_wrap");
        stop();
    endtask

    task automatic t_other();
        int w0;
        w0 = wrCnt;
        step(OP_START, 8'h00, 1'b0);
        wr({SLV ^ 7'h01, 1'b0}, 1'b0);
        wr(8'h05, 1'b0);
        wr(8'h77, 1'b0);
        stop();
        chk("foreign_writes", 8'(wrCnt - w0), 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        t_write();
        t_read();
        t_pcall();
        t_emul();
        t_edge();
        t_other();
        final_report();
    end
endmodule
